// >>> src/rpr_pkg.sv
// Purpose: Shared constants for the read-parameter register link.
// Assumes: Single-line serial framing, mode 0, most significant bit first.
// Notes: Opcodes, field positions and default dummy counts live here.
package rpr_pkg;
    localparam logic [7:0] OP_SET_PERSIST = 8'h65;
    localparam logic [7:0] OP_SET_WORK_A = 8'hc0;
    localparam logic [7:0] OP_SET_WORK_B = 8'h63;
    localparam logic [7:0] OP_FAST_SDR = 8'h0b;
    localparam logic [7:0] OP_FAST_SDR4 = 8'h0c;
    localparam logic [7:0] OP_FAST_DDR = 8'h0d;
    localparam logic [7:0] OP_FAST_DDR4 = 8'h0e;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
    localparam logic [7:0] OP_DUAL_OUT4 = 8'h3c;
    localparam logic [7:0] OP_DUAL_IO = 8'hbb;
    localparam logic [7:0] OP_DUAL_IO4 = 8'hbc;
    localparam logic [7:0] OP_DUAL_IO_DDR = 8'hbd;
    localparam logic [7:0] OP_DUAL_IO_DDR4 = 8'hbe;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] OP_QUAD_OUT4 = 8'h6c;
    localparam logic [7:0] OP_QUAD_IO = 8'heb;
    localparam logic [7:0] OP_QUAD_IO4 = 8'hec;
    localparam logic [7:0] OP_QUAD_IO_DDR = 8'hed;
    localparam logic [7:0] OP_QUAD_IO_DDR4 = 8'hee;
    localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
    localparam logic [7:0] OP_INFO_ROW = 8'h68;
    localparam logic [7:0] RP_RESET = 8'h00;
    localparam int PIN_ROLE_BIT = 7;
    localparam int DUMMY_HI = 6;
    localparam int DUMMY_LO = 3;
    localparam int WRAP_BIT = 2;
    localparam int BURST_HI = 1;
    localparam int BURST_LO = 0;
    localparam logic [3:0] DUMMY_FAST_SPI = 4'h8;
    localparam logic [3:0] DUMMY_FAST_QPI = 4'h6;
    localparam logic [3:0] DUMMY_OUT = 4'h8;
    localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
    localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
    localparam int SCK_HALF = 4;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_DATA = 3'h1;
    localparam logic [2:0] REG_STATUS = 3'h2;
    localparam int CTRL_GO = 0;
    localparam int CTRL_PERSIST = 1;
    localparam int CTRL_ALT_OP = 2;
endpackage : rpr_pkg

// >>> src/rpr_link_if.sv
// Purpose: Serial link between the controller and the register device.
// Assumes: Controller makes the serial clock and chip enable.
// Notes: Only the data-in line is used by the register set commands.
`timescale 1ns/1ps
interface rpr_link_if;
    logic sck;
    logic ce_n;
    logic sdi;
    modport dev (input sck, input ce_n, input sdi);
    modport ctl (output sck, output ce_n, output sdi);
endinterface : rpr_link_if

// >>> src/rpr_sync.sv
// Purpose: Two flip-flop synchroniser for link pins.
// Assumes: Inputs are asynchronous to clock.
// Notes: First stage is read only by the second; reset loads each line's idle level.
`timescale 1ns/1ps
module rpr_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // System.
    input wire logic clock,
    input wire logic rstn,
    // Data.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] stage;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta <= RST_VAL;
            stage <= RST_VAL;
        end else begin
            meta <= d;
            stage <= meta;
        end
    end

    // Starting at the idle levels keeps a false edge from following reset.
    assign q = stage;
endmodule : rpr_sync

// >>> src/rpr_device.sv
// Summary of operation
// - Two copies; working loads from persistent.
// - Opcode 65h then byte sets persistent.
// - Opcode C0h or 63h sets working.
// - Bit 7 picks hold or reset role.
// - Quad or four-line mode makes pin data_line_3.
// - Dedicated reset enabled forces hold role.
// - Bits 1:0 pick 8 to 64 bytes.
// - Wrap enable picks burst or array wrap.
// - Bits 6:3 give 1 to 15 dummies.
// - Zero field applies per-command defaults.
// - Identifier and info-row reads use fast defaults.
// - Listed read opcodes use the dummy setting.
// - Controller programs enough dummies for rate.
// - Controller leaves mode nibble floating when equal.
// - Double-rate dual read absent in four-line mode.
// - Separate-reset disable moves reset to shared pin.
//
// Purpose: Read-parameter register of a serial flash, with derived controls.
// Assumes: Single-line commands on the link; the link clock is sampled.
// Notes: Persistent copy is a register that survives rstn (power_on_n resets it).
// Notes: Only a complete opcode and data byte in one frame update a copy.
`timescale 1ns/1ps
module rpr_device #(
    parameter int ADDR_W = 24
) (
    // System.
    input wire logic clock,
    input wire logic rstn,
    input wire logic power_on_n,
    // Link.
    rpr_link_if.dev link,
    // Mode inputs.
    input wire logic quad_enable,
    input wire logic four_line_mode,
    input wire logic sep_reset_disable,
    input wire logic [7:0] read_opcode,
    input wire logic [ADDR_W-1:0] read_addr,
    input wire logic read_step,
    // Outputs.
    output logic [7:0] read_parameters,
    output logic [7:0] persist_parameters,
    output logic pin_is_reset,
    output logic pin_is_data_line_3,
    output logic [3:0] dummy_cycles,
    output logic read_refused,
    output logic [6:0] burst_bytes,
    output logic wrap_enable,
    output logic [ADDR_W-1:0] next_read_addr
);
    logic [2:0] pins;
    logic sck_d;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic have_op;
    typedef enum logic [1:0] {
        RPR_TGT_NONE = 2'b00,
        RPR_TGT_PERSIST = 2'b01,
        RPR_TGT_WORK = 2'b10
    } rpr_target_t;

    rpr_target_t target;
    logic load_pending;
    logic [7:0] next_byte;
    logic sck_rise;
    logic ce_n_s;
    logic write_done;

    // Default dummy count per read command, used when the dummy field is zero.
    function automatic logic [3:0] dflt_dummy(input logic [7:0] op, input logic qpi);
        unique case (op)
            rpr_pkg::OP_FAST_SDR, rpr_pkg::OP_FAST_SDR4, rpr_pkg::OP_FAST_DDR,
            rpr_pkg::OP_FAST_DDR4, rpr_pkg::OP_UNIQUE_ID, rpr_pkg::OP_INFO_ROW:
                dflt_dummy = qpi ? rpr_pkg::DUMMY_FAST_QPI : rpr_pkg::DUMMY_FAST_SPI;
            rpr_pkg::OP_DUAL_OUT, rpr_pkg::OP_DUAL_OUT4, rpr_pkg::OP_QUAD_OUT,
            rpr_pkg::OP_QUAD_OUT4:
                dflt_dummy = rpr_pkg::DUMMY_OUT;
            rpr_pkg::OP_DUAL_IO, rpr_pkg::OP_DUAL_IO4, rpr_pkg::OP_DUAL_IO_DDR,
            rpr_pkg::OP_DUAL_IO_DDR4:
                dflt_dummy = rpr_pkg::DUMMY_DUAL_IO;
            rpr_pkg::OP_QUAD_IO, rpr_pkg::OP_QUAD_IO4, rpr_pkg::OP_QUAD_IO_DDR,
            rpr_pkg::OP_QUAD_IO_DDR4:
                dflt_dummy = rpr_pkg::DUMMY_QUAD_IO;
            default:
                dflt_dummy = 4'h0;
        endcase
    endfunction : dflt_dummy

    // Link pins cross through two flip-flops; reset shows an idle, deselected link.
    rpr_sync #(.W(3), .RST_VAL(3'b010)) u_sync (
        .clock(clock),
        .rstn(rstn),
        .d({link.sck, link.ce_n, link.sdi}),
        .q(pins)
    );

    assign ce_n_s = pins[1];
    assign sck_rise = pins[2] & ~sck_d & ~ce_n_s;
    assign next_byte = {shreg[6:0], pins[0]};
    // The eighth rise of the second byte completes a set command.
    assign write_done = sck_rise && bit_cnt == 3'h7 && have_op;

    // Previous synchronised link clock, for rise detection.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= pins[2];
        end
    end

    // Shift in opcode then data byte; the target records which copy the byte is for.
    // A cut frame clears the decoder, so a partial byte never reaches either copy.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            have_op <= 1'b0;
            target <= RPR_TGT_NONE;
        end else if (ce_n_s) begin
            bit_cnt <= 3'h0;
            have_op <= 1'b0;
            target <= RPR_TGT_NONE;
        end else if (sck_rise) begin
            shreg <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                if (!have_op) begin
                    have_op <= 1'b1;
                    if (next_byte == rpr_pkg::OP_SET_PERSIST) begin
                        target <= RPR_TGT_PERSIST;
                    end else if (next_byte == rpr_pkg::OP_SET_WORK_A ||
                                 next_byte == rpr_pkg::OP_SET_WORK_B) begin
                        target <= RPR_TGT_WORK;
                    end else begin
                        target <= RPR_TGT_NONE;
                    end
                end else begin
                    target <= RPR_TGT_NONE;
                end
            end
        end
    end

    // Persistent copy: only power_on_n clears it, not the functional reset.
    always_ff @(posedge clock or negedge power_on_n) begin
        if (!power_on_n) begin
            persist_parameters <= rpr_pkg::RP_RESET;
        end else if (write_done && target == RPR_TGT_PERSIST) begin
            persist_parameters <= next_byte;
        end
    end

    // Working copy: reloads from the persistent copy on the first edge after reset.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            load_pending <= 1'b1;
            read_parameters <= rpr_pkg::RP_RESET;
        end else if (load_pending) begin
            load_pending <= 1'b0;
            read_parameters <= persist_parameters;
        end else if (write_done && target == RPR_TGT_WORK) begin
            read_parameters <= next_byte;
        end
    end

    // Pin role and read timing decode.
    // Each output follows the working copy and the mode inputs one edge later.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_is_reset <= 1'b0;
            pin_is_data_line_3 <= 1'b0;
            dummy_cycles <= 4'h0;
            read_refused <= 1'b0;
            burst_bytes <= 7'd8;
            wrap_enable <= 1'b0;
        end else begin
            pin_is_data_line_3 <= quad_enable | four_line_mode;
            pin_is_reset <= !(quad_enable | four_line_mode) && sep_reset_disable
                            && read_parameters[rpr_pkg::PIN_ROLE_BIT];
            if (read_parameters[rpr_pkg::DUMMY_HI:rpr_pkg::DUMMY_LO] != 4'h0) begin
                dummy_cycles <= read_parameters[rpr_pkg::DUMMY_HI:rpr_pkg::DUMMY_LO];
            end else begin
                dummy_cycles <= dflt_dummy(read_opcode, four_line_mode);
            end
            read_refused <= four_line_mode && (read_opcode == rpr_pkg::OP_DUAL_IO_DDR ||
                            read_opcode == rpr_pkg::OP_DUAL_IO_DDR4);
            burst_bytes <= 7'd8 << read_parameters[rpr_pkg::BURST_HI:rpr_pkg::BURST_LO];
            wrap_enable <= read_parameters[rpr_pkg::WRAP_BIT];
        end
    end

    // Address stepping for a continuous read.
    // Without wrap the address rolls over only at the top of the array.
    logic [ADDR_W-1:0] win_mask;
    logic [ADDR_W-1:0] inc_addr;
    assign win_mask = ADDR_W'(burst_bytes) - ADDR_W'(1);
    assign inc_addr = read_addr + ADDR_W'(1);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            next_read_addr <= '0;
        end else if (read_step) begin
            if (wrap_enable) begin
                next_read_addr <= (read_addr & ~win_mask) | (inc_addr & win_mask);
            end else begin
                next_read_addr <= inc_addr;
            end
        end
    end
endmodule : rpr_device

// >>> src/rpr_controller.sv
// Purpose: Host end that writes the read-parameter register over the link.
// Assumes: Avalon-MM slave with waitrequest for software.
// Notes: Sends opcode then byte, most significant bit first, mode 0.
`timescale 1ns/1ps
module rpr_controller (
    // System.
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM slave.
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Link.
    rpr_link_if.ctl link
);
    typedef enum logic [1:0] {
        RPC_IDLE = 2'b00,
        RPC_LOW = 2'b01,
        RPC_HIGH = 2'b10,
        RPC_DONE = 2'b11
    } rpc_state_t;

    rpc_state_t state;
    logic [15:0] shift;
    logic [4:0] bits_left;
    logic [2:0] div;
    logic [7:0] data_reg;
    logic [2:0] ctrl_reg;
    logic busy;
    logic ack;
    logic go;

    assign go = write && !ack && address == rpr_pkg::REG_CTRL && writedata[rpr_pkg::CTRL_GO];

    // One wait state on every access, answer on the second cycle.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            ack <= (read | write) && !ack;
            unique case (address)
                rpr_pkg::REG_CTRL: readdata <= {29'h0, ctrl_reg};
                rpr_pkg::REG_DATA: readdata <= {24'h0, data_reg};
                rpr_pkg::REG_STATUS: readdata <= {31'h0, busy};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end
    assign waitrequest = (read | write) && !ack;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            data_reg <= 8'h00;
            ctrl_reg <= 3'h0;
        end else if (write && !ack && !busy) begin
            if (address == rpr_pkg::REG_DATA) begin
                data_reg <= writedata[7:0];
            end else if (address == rpr_pkg::REG_CTRL) begin
                ctrl_reg <= {writedata[rpr_pkg::CTRL_ALT_OP:rpr_pkg::CTRL_PERSIST], 1'b0};
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= RPC_IDLE;
            shift <= 16'h0000;
            bits_left <= 5'd0;
            div <= 3'd0;
            busy <= 1'b0;
            link.sck <= 1'b0;
            link.ce_n <= 1'b1;
            link.sdi <= 1'b0;
        end else begin
            unique case (state)
                RPC_IDLE: begin
                    if (go && !busy) begin
                        busy <= 1'b1;
                        if (writedata[rpr_pkg::CTRL_PERSIST]) begin
                            shift <= {rpr_pkg::OP_SET_PERSIST, data_reg};
                        end else if (writedata[rpr_pkg::CTRL_ALT_OP]) begin
                            shift <= {rpr_pkg::OP_SET_WORK_B, data_reg};
                        end else begin
                            shift <= {rpr_pkg::OP_SET_WORK_A, data_reg};
                        end
                        bits_left <= 5'd16;
                        div <= 3'd0;
                        link.ce_n <= 1'b0;
                        state <= RPC_LOW;
                    end
                end
                RPC_LOW: begin
                    link.sdi <= shift[15];
                    if (div == 3'(rpr_pkg::SCK_HALF - 1)) begin
                        div <= 3'd0;
                        link.sck <= 1'b1;
                        shift <= {shift[14:0], 1'b0};
                        bits_left <= bits_left - 5'd1;
                        state <= RPC_HIGH;
                    end else begin
                        div <= div + 3'd1;
                    end
                end
                RPC_HIGH: begin
                    if (div == 3'(rpr_pkg::SCK_HALF - 1)) begin
                        div <= 3'd0;
                        link.sck <= 1'b0;
                        state <= (bits_left == 5'd0) ? RPC_DONE : RPC_LOW;
                    end else begin
                        div <= div + 3'd1;
                    end
                end
                RPC_DONE: begin
                    if (div == 3'(rpr_pkg::SCK_HALF - 1)) begin
                        link.ce_n <= 1'b1;
                        busy <= 1'b0;
                        state <= RPC_IDLE;
                    end else begin
                        div <= div + 3'd1;
                    end
                end
            endcase
        end
    end
endmodule : rpr_controller

// >>> verif/rpr_link_asserts.sv
// Purpose: Wire checks on the link between controller and register device.
// Assumes: Mode 0 framing, half period of four clocks, sixteen bits a frame.
// Notes: Watches only the link signals, with the controller's clock and reset.
`timescale 1ns/1ps
module rpr_link_asserts (
    // System.
    input wire logic clock,
    input wire logic rstn,
    // Link.
    input wire logic sck,
    input wire logic ce_n,
    input wire logic sdi
);
    logic sck_q;
    logic [4:0] bits;
    logic [7:0] lo_cnt;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // Counts clock rises and low cycles of the chip enable within each frame.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sck_q <= 1'b0;
            bits <= 5'h00;
            lo_cnt <= 8'h00;
        end else begin
            sck_q <= sck;
            bits <= ce_n ? 5'h00 : bits + 5'(sck & ~sck_q);
            lo_cnt <= ce_n ? 8'h00 : lo_cnt + 8'h01;
        end
    end
    sequence s_high_half;
        sck [*4] ##1 !sck;
    endsequence
    sequence s_first_rise;
        !sck ##[1:16] sck;
    endsequence
    a_idle_sck_low: assert property (ce_n |-> !sck)
        else $error("link clock moved outside a frame");
    a_reset_idle: assert property ($rose(rstn) |-> ce_n && !sck)
        else $error("link not idle after reset");
    a_high_half: assert property ($rose(sck) |-> s_high_half)
        else $error("link clock high phase not four cycles");
    a_low_half: assert property ($fell(sck) |-> !sck [*4])
        else $error("link clock low phase too short");
    a_sdi_steady: assert property (sck |-> $stable(sdi))
        else $error("data changed while link clock high");
    a_ce_quiet: assert property ($rose(ce_n) |-> !sck && !$past(sck))
        else $error("chip enable rose near a clock edge");
    a_frame_bits: assert property ($rose(ce_n) |-> bits == 5'h10)
        else $error("frame does not hold sixteen bits");
    a_frame_len: assert property ($rose(ce_n) |-> lo_cnt >= 8'h80 && lo_cnt <= 8'ha0)
        else $error("frame length out of range");
    a_first_rise: assert property ($fell(ce_n) |-> s_first_rise)
        else $error("no clock rise soon after frame start");
endmodule : rpr_link_asserts

// >>> verif/tb.sv
// Purpose: Self-checking bench joining controller and register device.
// Assumes: Software writes through Avalon-MM; device modes driven directly.
// Notes: Random values come from a sixteen-bit shift register seeded at 57.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic power_on_n = 1'b0;
    logic [2:0] address = 3'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rdata;
    logic waitrequest;
    logic quad_enable = 1'b0;
    logic four_line_mode = 1'b0;
    logic sep_reset_disable = 1'b0;
    logic [7:0] read_opcode = 8'h0b;
    logic [23:0] read_addr = 24'h0;
    logic read_step = 1'b0;
    logic [7:0] read_parameters, persist_parameters, w_exp, p_exp;
    logic pin_is_reset, pin_is_data_line_3, read_refused, wrap_enable;
    logic [3:0] dummy_cycles;
    logic [6:0] burst_bytes;
    logic [23:0] next_read_addr, ea;
    logic [15:0] seed = 16'h0039;
    logic [7:0] corner[3] = '{8'h80, 8'h7f, 8'h00};
    logic [7:0] wv[3] = '{8'h0c, 8'h0f, 8'h08};
    logic [7:0] ops[18] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h4b, 8'h68, 8'h3b, 8'h3c, 8'h6b,
        8'h6c, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'heb, 8'hec, 8'hed, 8'hee};
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    rpr_link_if link ();
    always #12.5 clock = ~clock;
    rpr_controller rpr_controller_inst (.clock(clock), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .link(link.ctl));
    rpr_device #(.ADDR_W(24)) rpr_device_inst (.clock(clock), .rstn(rstn),
        .power_on_n(power_on_n), .link(link.dev), .quad_enable(quad_enable),
        .four_line_mode(four_line_mode), .sep_reset_disable(sep_reset_disable),
        .read_opcode(read_opcode), .read_addr(read_addr), .read_step(read_step),
        .read_parameters(read_parameters), .persist_parameters(persist_parameters),
        .pin_is_reset(pin_is_reset), .pin_is_data_line_3(pin_is_data_line_3),
        .dummy_cycles(dummy_cycles), .read_refused(read_refused), .burst_bytes(burst_bytes),
        .wrap_enable(wrap_enable), .next_read_addr(next_read_addr));
    rpr_link_asserts rpr_link_asserts_inst (.clock(clock), .rstn(rstn), .sck(link.sck),
        .ce_n(link.ce_n), .sdi(link.sdi));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [3:0] def_dummy(input logic [7:0] op, input logic four);
        case (op)
            8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h4b, 8'h68: return four ? 4'h6 : 4'h8;
            8'h3b, 8'h3c, 8'h6b, 8'h6c: return 4'h8;
            8'hbb, 8'hbc, 8'hbd, 8'hbe: return 4'h4;
            default: return 4'h6;
        endcase
    endfunction : def_dummy
    // Holds the request until the rising edge at which waitrequest is sampled low.
    task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write <= w;
        read <= ~w;
        writedata <= d;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rdata = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : av
    task automatic put(input logic [1:0] kind, input logic [7:0] v);
        int n;
        n = 0;
        av(1'b1, 3'h1, {24'h0, v});
        av(1'b1, 3'h0, {29'h0, kind == 2'h1, kind == 2'h2, 1'b1});
        rdata = 32'h1;
        while (rdata[0] !== 1'b0 && n < 100) begin
            av(1'b0, 3'h2, 32'h0);
            n++;
        end
        if (n >= 100) num_errors++;
        av(1'b0, 3'h1, 32'h0);
        `CHK("data", {24'h0, v}, rdata)
        repeat (10) @(posedge clock);
        if (kind == 2'h2) p_exp = v;
        else w_exp = v;
        `CHK("working", w_exp, read_parameters)
        `CHK("persistent", p_exp, persist_parameters)
    endtask : put
    task automatic chk_fields();
        logic er;
        logic [3:0] ed;
        repeat (4) @(posedge clock);
        er = w_exp[7] & ~quad_enable & ~four_line_mode & sep_reset_disable;
        ed = (w_exp[6:3] != 4'h0) ? w_exp[6:3] : def_dummy(read_opcode, four_line_mode);
        `CHK("burst", 7'h08 << w_exp[1:0], burst_bytes)
        `CHK("wrap", w_exp[2], wrap_enable)
        `CHK("role", er, pin_is_reset)
        `CHK("line3", quad_enable | four_line_mode, pin_is_data_line_3)
        `CHK("dummy", ed, dummy_cycles)
    endtask : chk_fields
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        power_on_n <= 1'b1;
        repeat (3) @(posedge clock);
        w_exp = 8'h00;
        p_exp = 8'h00;
        `CHK("reset working", 8'h00, read_parameters)
        `CHK("reset persistent", 8'h00, persist_parameters)
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            put(2'(k % 3), seed[7:0]);
        end
        av(1'b0, 3'h5, 32'h0);
        `CHK("unmapped", 32'h0, rdata)
        $display("test writes done");
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        w_exp = p_exp;
        `CHK("reload", p_exp, read_parameters)
        $display("test reload done");
        for (int k = 0; k < 15; k++) begin
            seed = lfsr(seed);
            put({1'b0, seed[8]}, (k < 3) ? corner[k] : seed[7:0]);
            {sep_reset_disable, four_line_mode, quad_enable} <= (k < 3) ? 3'h4 : seed[12:10];
            chk_fields();
        end
        $display("test fields done");
        put(2'h0, 8'h00);
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 18; i++) begin
                four_line_mode <= f[0];
                read_opcode <= ops[i];
                repeat (4) @(posedge clock);
                `CHK("refused", (f[0] && ops[i] inside {8'hbd, 8'hbe}), read_refused)
                if (f == 0 || def_dummy(ops[i], 1'b1) == 4'h6) begin
                    `CHK("default", def_dummy(ops[i], f[0]), dummy_cycles)
                end
            end
        end
        $display("test defaults done");
        for (int j = 0; j < 3; j++) begin
            put(2'h0, wv[j]);
            seed = lfsr(seed);
            read_addr <= {8'h12, seed | 16'h003f};
            read_step <= 1'b1;
            @(posedge clock);
            read_step <= 1'b0;
            repeat (3) @(posedge clock);
            ea = wv[j][2] ? read_addr & ~((24'h8 << wv[j][1:0]) - 24'h1) : read_addr + 24'h1;
            `CHK("next address", ea, next_read_addr)
        end
        $display("test wrap done");
        report_and_stop();
    end
endmodule : tb
